// ==== rtl/ccs_consts.svh ====
/*
  constants of the clock switch and reference clock output block:
  register offsets, field positions, unlock keys, reset values, counts.
  assumes it is included by bare name after the package.
*/
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// ==========================================================
// register offsets on the plain register port
`define CCS_ADDR_OSC_LO 4'h0
`define CCS_ADDR_OSC_HI 4'h1
`define CCS_ADDR_REF 4'h2

// ==========================================================
// unlock keys for the two halves of the oscillator control
`define CCS_KEY_HI_1 8'h78
`define CCS_KEY_HI_2 8'h9a
`define CCS_KEY_LO_1 8'h46
`define CCS_KEY_LO_2 8'h57

// ==========================================================
// oscillator control field positions (full 16-bit word)
`define CCS_OSC_CUR_LSB 12
`define CCS_OSC_NEW_LSB 8
`define CCS_OSC_LOCK_BIT 5
`define CCS_OSC_CF_BIT 3
`define CCS_OSC_SECONDARY_OSC_ENABLE_BIT 1
`define CCS_OSC_REQ_BIT 0

// ==========================================================
// reference clock control field positions and reset value
`define CCS_REF_EN_BIT 15
`define CCS_REF_SLP_BIT 13
`define CCS_REF_SEL_BIT 12
`define CCS_REF_DIV_LSB 8
`define CCS_REF_RESET 16'h0000

// ==========================================================
// physical oscillator enable lanes
`define CCS_OSC_FRC 0
`define CCS_OSC_POSC 1
`define CCS_OSC_SECONDARY_OSC 2
`define CCS_OSC_LOW_POWER_RC_OSC 3
`define CCS_OSC_LPFRC 4

// ==========================================================
// timing counts, in cycles
`define CCS_OST_CYCLES 11'h400
`define CCS_SETTLE_CYCLES 11'h00a

`endif

// ==== rtl/ccs_pkg.sv ====
/*
  types and shared decode functions of the clock switch block.
  assumes nothing of its surroundings.
*/
package ccs_pkg;

  // ========================================================
  // switch sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CHECK  = 3'b001,
    ST_START  = 3'b010,
    ST_PLL    = 3'b011,
    ST_SETTLE = 3'b100,
    ST_COMMIT = 3'b101
  } ccs_state_t;

  // ========================================================
  // clock source codes
  typedef enum logic [2:0] {
    SRC_FRC     = 3'b000,
    SRC_INTERNAL_RC_WITH_PLL  = 3'b001,
    SRC_POSC    = 3'b010,
    SRC_POSCPLL = 3'b011,
    SRC_SECONDARY_OSC    = 3'b100,
    SRC_LOW_POWER_RC_OSC    = 3'b101,
    SRC_LPFRC   = 3'b110,
    SRC_FRCDIV  = 3'b111
  } ccs_src_t;

  // source code runs through the pll
  function automatic logic ccs_uses_pll(input ccs_src_t s);
    ccs_uses_pll = (s == SRC_INTERNAL_RC_WITH_PLL) || (s == SRC_POSCPLL);
  endfunction

  // physical oscillator lanes that a source code needs
  function automatic logic [4:0] ccs_osc_lanes(input ccs_src_t s);
    case (s)
      SRC_FRC, SRC_INTERNAL_RC_WITH_PLL, SRC_FRCDIV: ccs_osc_lanes = 5'h01;
      SRC_POSC, SRC_POSCPLL: ccs_osc_lanes = 5'h02;
      SRC_SECONDARY_OSC: ccs_osc_lanes = 5'h04;
      SRC_LOW_POWER_RC_OSC: ccs_osc_lanes = 5'h08;
      SRC_LPFRC: ccs_osc_lanes = 5'h10;
      default: ccs_osc_lanes = 5'h00;
    endcase
  endfunction

endpackage

// ==== rtl/ccs_count.sv ====
/*
  down counter with a sticky done level, used for the crystal
  start-up wait and for the new-clock settle count.
  assumes tick is a one-cycle pulse synchronous to clk.
*/
`timescale 1ns/1ns
`include "ccs_consts.svh"

module ccs_count import ccs_pkg::*; (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // control
  input wire logic load,
  input wire logic [10:0] load_val,
  input wire logic tick,
  // status
  output logic done
);

  logic [10:0] cnt; // ticks still to go

  // ========================================================
  // load, then count ticks down to zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 11'h000;
      done <= 1'b1;
    end else if (ce) begin
      if (load) begin
        cnt <= load_val;
        done <= (load_val == 11'h000);
      end else if (tick && (cnt != 11'h000)) begin
        cnt <= cnt - 11'h001;
        done <= (cnt == 11'h001);
      end
    end
  end

endmodule

// ==== rtl/ccs_ref_div.sv ====
/*
  reference clock divider: divides a base tick stream by a power of
  two and drives the reference pin with its output enable.
  assumes base_tick is a one-cycle pulse synchronous to clk.
*/
`timescale 1ns/1ns
`include "ccs_consts.svh"

module ccs_ref_div import ccs_pkg::*; (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic base_tick,
  input wire logic [3:0] div,
  // pin
  output logic pin,
  output logic pin_oe
);

  logic [13:0] cnt; // base ticks seen
  logic [13:0] mask; // half period minus one
  logic hit; // half period reached

  // half period of a divide by two to the power d, less one
  function automatic logic [13:0] half_mask(input logic [3:0] d);
    logic [15:0] one;
    one = 16'h0001 << d;
    half_mask = one[14:1] - 14'h0001;
  endfunction

  assign mask = half_mask(div);
  assign hit = ((cnt & mask) == mask);

  // ========================================================
  // toggle the pin every half period of base ticks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 14'h0000;
      pin <= 1'b0;
      pin_oe <= 1'b0;
    end else if (ce) begin
      pin_oe <= run;
      if (!run) begin
        cnt <= 14'h0000;
        pin <= 1'b0;
      end else if (div == 4'h0) begin
        pin <= base_tick; // undivided
      end else if (base_tick) begin
        cnt <= cnt + 14'h0001;
        if (hit) begin
          pin <= ~pin; // divide by two to the div
        end
      end
    end
  end

endmodule

// ==== rtl/ccs_top.sv ====
/*
  clock source switch controller and reference clock output.
  holds the keyed oscillator control register, the switch sequencer
  and the reference control register.
  assumes a register master on the plain port, oscillator status
  inputs synchronous to clk, and clocks given as tick pulses.
*/
`timescale 1ns/1ns
`include "ccs_consts.svh"

module ccs_top import ccs_pkg::*; (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // configuration straps
  input wire logic [2:0] cfg_fnosc,
  input wire logic cfg_posc_crystal,
  input wire logic cfg_secondary_osc_crystal,
  input wire logic cfg_posc_mode,
  input wire logic watchdog_on,
  input wire logic fail_safe_clock_monitor_on,
  // oscillator side
  input wire logic [4:0] osc_running,
  input wire logic pll_lock_in,
  input wire logic clock_fail_in,
  input wire logic new_clk_tick,
  input wire logic posc_tick,
  input wire logic sys_tick,
  input wire logic sleep_mode,
  // oscillator control outputs
  output logic [4:0] osc_enable,
  output logic [2:0] sys_clk_sel,
  // reference clock pin
  output logic ref_clock_pin,
  output logic ref_clock_pin_oe
);

  // ========================================================
  // state
  logic started; // cfg_fnosc strap captured after reset
  ccs_state_t state, next_state; // switch sequencer
  ccs_src_t current_source_sel, next_current;
  ccs_src_t new_source_sel, next_new;
  logic switch_request, next_request;
  logic lock, next_lock; // pll lock status
  logic clock_fail_flag, next_cf; // sticky clock failure
  logic secondary_osc_enable, next_secondary_osc_en;
  logic [1:0] hi_key, next_hi_key; // high byte unlock stage
  logic [1:0] lo_key, next_lo_key; // low byte unlock stage
  logic ref_out_enable, ref_run_in_sleep, ref_source_select;
  logic [3:0] ref_divisor;
  logic [4:0] next_osc_enable;
  logic [15:0] next_rdata;

  // ========================================================
  // register port decode
  wire wr_act = wr & ce;
  wire wr_lo = wr_act & (addr == `CCS_ADDR_OSC_LO);
  wire wr_hi = wr_act & (addr == `CCS_ADDR_OSC_HI);
  wire wr_ref = wr_act & (addr == `CCS_ADDR_REF);
  wire hi_open = (hi_key == 2'h2); // next write may land
  wire lo_open = (lo_key == 2'h2);
  wire hi_accept = wr_hi & hi_open;
  wire lo_accept = wr_lo & lo_open;
  wire [7:0] wbyte = wdata[7:0];

  // ========================================================
  // unlock key tracking: any other write breaks a sequence
  always_comb begin
    next_hi_key = hi_key;
    next_lo_key = lo_key;
    if (wr_act) begin
      // high byte keys
      if (wr_hi && hi_key == 2'h1 && wbyte == `CCS_KEY_HI_2) begin
        next_hi_key = 2'h2;
      end else if (wr_hi && wbyte == `CCS_KEY_HI_1) begin
        next_hi_key = 2'h1;
      end else begin
        next_hi_key = 2'h0;
      end
      // low byte keys
      if (wr_lo && lo_key == 2'h1 && wbyte == `CCS_KEY_LO_2) begin
        next_lo_key = 2'h2;
      end else if (wr_lo && wbyte == `CCS_KEY_LO_1) begin
        next_lo_key = 2'h1;
      end else begin
        next_lo_key = 2'h0;
      end
    end
  end

  // ========================================================
  // sequencer decode
  wire same = (current_source_sel == new_source_sel);
  wire busy = (state != ST_IDLE);
  wire tgt_pll = ccs_uses_pll(new_source_sel);
  wire [4:0] tgt_lanes = ccs_osc_lanes(new_source_sel);
  wire [4:0] cur_lanes = ccs_osc_lanes(current_source_sel);
  wire tgt_ready = |(tgt_lanes & osc_running);
  wire tgt_xtal = (tgt_lanes[`CCS_OSC_POSC] & cfg_posc_crystal) |
                  (tgt_lanes[`CCS_OSC_SECONDARY_OSC] & cfg_secondary_osc_crystal);
  wire ost_done; // crystal start-up timer expired
  wire settle_done; // ten new-clock cycles seen
  wire valid_go = (state == ST_CHECK) & ~same;
  wire [10:0] ost_val = tgt_xtal ? `CCS_OST_CYCLES : 11'h000;
  wire settle_load = (next_state == ST_SETTLE) &
                     (state != ST_SETTLE);

  // ========================================================
  // sequencer next state; the cpu is never stalled
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (switch_request) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // redundant request aborts
        next_state = same ? ST_IDLE : ST_START;
      end
      ST_START: begin
        // oscillator up and crystal timer out
        if (tgt_ready && ost_done) begin
          next_state = tgt_pll ? ST_PLL : ST_SETTLE;
        end
      end
      ST_PLL: begin
        // hold for pll lock
        if (pll_lock_in) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // ten new-clock cycles
        if (settle_done) begin
          next_state = ST_COMMIT;
        end
      end
      ST_COMMIT: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ========================================================
  // oscillator control field next values
  always_comb begin
    next_new = new_source_sel;
    next_current = current_source_sel;
    next_request = switch_request;
    next_secondary_osc_en = secondary_osc_enable;
    next_cf = clock_fail_flag;
    if (!started) begin
      next_new = ccs_src_t'(cfg_fnosc);
      next_current = ccs_src_t'(cfg_fnosc);
    end else if (hi_accept) begin
      next_new = ccs_src_t'(wdata[2:0]);
    end
    if (state == ST_COMMIT) begin
      next_current = new_source_sel;
    end
    // hardware clears; a software set in the same cycle wins
    if ((state == ST_CHECK && same) || state == ST_COMMIT) begin
      next_request = 1'b0;
    end
    if (lo_accept) begin
      next_secondary_osc_en = wbyte[`CCS_OSC_SECONDARY_OSC_ENABLE_BIT];
      if (wbyte[`CCS_OSC_REQ_BIT]) begin
        next_request = 1'b1;
      end
    end
    // failure flag: cleared by a valid switch, set wins
    if (valid_go) begin
      next_cf = 1'b0;
    end
    if (clock_fail_in) begin
      next_cf = 1'b1;
    end
    // lock status follows the pll of the target source while switching, else of the current one
    if (valid_go) begin
      next_lock = 1'b0;
    end else if (busy) begin
      next_lock = tgt_pll & pll_lock_in;
    end else begin
      next_lock = ccs_uses_pll(current_source_sel) & pll_lock_in;
    end
  end

  // ========================================================
  // reference output run condition and base clock
  wire sleep_keep = ref_run_in_sleep & ref_source_select &
                    cfg_posc_mode;
  wire ref_run = ref_out_enable &
                 (~sleep_mode | sleep_keep);
  wire ref_base = ref_source_select ? posc_tick
                                    : sys_tick;

  // ========================================================
  // oscillator enables: old source drops once current moves
  wire low_power_rc_osc_keep = watchdog_on | fail_safe_clock_monitor_on;
  always_comb begin
    next_osc_enable = cur_lanes;
    if (busy) begin
      next_osc_enable = next_osc_enable | tgt_lanes;
    end
    if (low_power_rc_osc_keep) begin
      next_osc_enable[`CCS_OSC_LOW_POWER_RC_OSC] = 1'b1;
    end
    if (secondary_osc_enable) begin
      next_osc_enable[`CCS_OSC_SECONDARY_OSC] = 1'b1;
    end
    if (sleep_mode && !sleep_keep) begin
      next_osc_enable[`CCS_OSC_POSC] = 1'b0;
    end
  end

  // ========================================================
  // read mux; unused bits read zero
  wire [15:0] osc_word = {1'b0, current_source_sel, 1'b0,
                          new_source_sel, 2'b00, lock, 1'b0,
                          clock_fail_flag, 1'b0,
                          secondary_osc_enable, switch_request};
  wire [15:0] ref_word = {ref_out_enable, 1'b0, ref_run_in_sleep,
                          ref_source_select, ref_divisor,
                          8'h00};
  always_comb begin
    next_rdata = 16'h0000;
    if (rd) begin
      case (addr)
        `CCS_ADDR_OSC_LO: next_rdata = osc_word;
        `CCS_ADDR_OSC_HI: next_rdata = {8'h00, osc_word[15:8]};
        `CCS_ADDR_REF: next_rdata = ref_word;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // ========================================================
  // sequencer and oscillator control registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      started <= 1'b0;
      state <= ST_IDLE;
      current_source_sel <= SRC_FRC;
      new_source_sel <= SRC_FRC;
      switch_request <= 1'b0;
      lock <= 1'b0;
      clock_fail_flag <= 1'b0;
      secondary_osc_enable <= 1'b0;
      hi_key <= 2'h0;
      lo_key <= 2'h0;
    end else if (ce) begin
      started <= 1'b1;
      state <= next_state;
      current_source_sel <= next_current;
      new_source_sel <= next_new;
      switch_request <= next_request;
      lock <= next_lock;
      clock_fail_flag <= next_cf;
      secondary_osc_enable <= next_secondary_osc_en;
      hi_key <= next_hi_key;
      lo_key <= next_lo_key;
    end
  end

  // ========================================================
  // reference control register, plain word write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_out_enable <= 1'b0;
      ref_run_in_sleep <= 1'b0;
      ref_source_select <= 1'b0;
      ref_divisor <= 4'h0;
    end else if (wr_ref) begin
      ref_out_enable <= wdata[`CCS_REF_EN_BIT];
      ref_run_in_sleep <= wdata[`CCS_REF_SLP_BIT];
      ref_source_select <= wdata[`CCS_REF_SEL_BIT];
      ref_divisor <= wdata[`CCS_REF_DIV_LSB +: 4];
    end
  end

  // ========================================================
  // registered outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
      osc_enable <= 5'h00;
      sys_clk_sel <= 3'h0;
    end else if (ce) begin
      rdata <= next_rdata;
      osc_enable <= next_osc_enable;
      sys_clk_sel <= current_source_sel;
    end
  end

  // ========================================================
  // crystal start-up timer and new-clock settle counter
  ccs_count u_ost (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .load(valid_go),
    .load_val(ost_val),
    .tick(1'b1),
    .done(ost_done)
  );

  ccs_count u_settle (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .load(settle_load),
    .load_val(`CCS_SETTLE_CYCLES),
    .tick(new_clk_tick),
    .done(settle_done)
  );

  // ========================================================
  // reference clock divider
  ccs_ref_div u_ref (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .run(ref_run),
    .base_tick(ref_base),
    .div(ref_divisor),
    .pin(ref_clock_pin),
    .pin_oe(ref_clock_pin_oe)
  );

  // ========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence seq_commit;
    (state == ST_COMMIT) && ce;
  endsequence

  AST_HI_LOCKED: assert property (
    (wr_hi && !hi_open && started) |=> $stable(new_source_sel))
    else $error("locked high byte write changed new source");
  AST_HI_OPEN: assert property (
    (hi_accept && started) |=> new_source_sel == $past(wdata[2:0]))
    else $error("unlocked high byte write not taken");
  AST_LO_LOCKED: assert property (
    (wr_lo && !lo_open) |=> $stable(secondary_osc_enable))
    else $error("locked low byte write changed a field");
  AST_REDUNDANT: assert property (
    (state == ST_CHECK && same && ce && !lo_accept) |=>
      (!switch_request && state == ST_IDLE))
    else $error("redundant switch not aborted");
  AST_CLEAR_FLAGS: assert property (
    (valid_go && ce && !clock_fail_in) |=>
      (!lock && !clock_fail_flag))
    else $error("valid switch left lock or fail flag set");
  AST_OST_WAIT: assert property (
    (state == ST_START && !ost_done) |=> state == ST_START)
    else $error("left start before crystal timer expired");
  AST_PLL_WAIT: assert property (
    (state == ST_PLL && !pll_lock_in) |=> state == ST_PLL)
    else $error("left pll wait without lock");
  AST_COMMIT: assert property (
    seq_commit |=> (current_source_sel == $past(new_source_sel)
                    && (!switch_request || $past(lo_accept))))
    else $error("commit did not copy source or clear request");
  AST_REF_OFF: assert property (
    (!ref_run && ce) |=> !ref_clock_pin_oe)
    else $error("reference pin driven while disabled");
  AST_REF_ZERO: assert property (
    (rd && ce && addr == `CCS_ADDR_REF) |=>
      (rdata[14] == 1'b0 && rdata[7:0] == 8'h00))
    else $error("reserved reference bits read nonzero");

endmodule

// ==== verif/ccs_top_tb.sv ====
/*
  self-checking bench of the clock switch and reference output block.
  assumes ccs_pkg is compiled first; bench drives every port itself.
*/
`timescale 1ns/1ns
`include "ccs_consts.svh"

module ccs_top_tb import ccs_pkg::*;;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 0, rstn = 0, ce = 1, wr = 0, rd = 0;
  logic [3:0] addr = 0;
  logic [15:0] wdata = 0, rdata, d;
  logic [2:0] cfg_fnosc = 0, sys_clk_sel;
  logic xtal = 1, secondary_osc_x = 0, pmode = 1, wdog = 0, fail_safe_clock_monitor = 0;
  logic [4:0] osc_running = 5'h1d, osc_enable;
  logic lock_in = 0, fail_in = 0, nck = 0, posc_tick = 0, sys_tick = 0;
  logic sleep_mode = 0, pin, pin_oe;
  int n_fail = 0, samples_checked = 0, t;

  ccs_top ccs_top_inst (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cfg_fnosc(cfg_fnosc),
    .cfg_posc_crystal(xtal), .cfg_secondary_osc_crystal(secondary_osc_x),
    .cfg_posc_mode(pmode), .watchdog_on(wdog),
    .fail_safe_clock_monitor_on(fail_safe_clock_monitor), .osc_running(osc_running),
    .pll_lock_in(lock_in), .clock_fail_in(fail_in), .new_clk_tick(nck),
    .posc_tick(posc_tick), .sys_tick(sys_tick), .sleep_mode(sleep_mode),
    .osc_enable(osc_enable), .sys_clk_sel(sys_clk_sel),
    .ref_clock_pin(pin), .ref_clock_pin_oe(pin_oe));

  // ==========================================================
  // clock and primary oscillator pulses (one every other cycle)
  always #10 clk = ~clk;
  always @(posedge clk) posc_tick <= ~posc_tick;

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one write cycle, strobe dropped at the next edge
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk) begin addr <= a; wdata <= v; wr <= 1; end
    @(posedge clk) wr <= 0;
  endtask

  // one read cycle, data taken in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk) begin addr <= a; rd <= 1; end
    @(posedge clk) rd <= 0;
    #1 d = rdata;
  endtask

  // keyed write of the new source, then keyed switch request
  task automatic set_new(input ccs_src_t s);
    wr_reg(`CCS_ADDR_OSC_HI, 16'h0078);
    wr_reg(`CCS_ADDR_OSC_HI, 16'h009a); // no write between keys
    wr_reg(`CCS_ADDR_OSC_HI, {13'h0000, s});
  endtask

  task automatic request;
    wr_reg(`CCS_ADDR_OSC_LO, 16'h0046);
    wr_reg(`CCS_ADDR_OSC_LO, 16'h0057); // no write between keys
    wr_reg(`CCS_ADDR_OSC_LO, 16'h0001);
  endtask

  // pulses of the new clock
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk) nck <= 1;
      @(posedge clk) nck <= 0;
    end
  endtask

  // poll the request bit under a bound
  task automatic wait_done;
    for (int i = 0; i < 20; i++) begin
      rd_reg(`CCS_ADDR_OSC_LO);
      if (d[0] === 1'b0) break;
    end
    chk(d[0], 0, "request cleared");
  endtask

  // cycles to the next rising edge of the reference pin, 300 if none
  task automatic wait_rise;
    logic p;
    p = pin;
    for (t = 1; t < 300; t++) begin
      @(posedge clk);
      #1;
      if (p === 1'b0 && pin === 1'b1) break;
      p = pin;
    end
  endtask

  task automatic ref_period(input logic [15:0] ctl, input int exp);
    wr_reg(`CCS_ADDR_REF, ctl);
    // the first period after a divisor change may be uneven
    wait_rise;
    wait_rise;
    wait_rise;
    chk(16'(t), 16'(exp), "ref period");
    chk(pin_oe, ctl[15], "ref enable");
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_keys;
    // a write while the clock enable is low must not land
    ce <= 0;
    wr_reg(`CCS_ADDR_REF, 16'h8000);
    ce <= 1;
    rd_reg(`CCS_ADDR_REF);
    chk(d, `CCS_REF_RESET, "ref reset");
    rd_reg(4'h3);
    chk(d, 16'h0000, "unmapped read");
    request;
    wait_done;
    chk(d[14:12], 3'h0, "same source kept");
    wr_reg(`CCS_ADDR_OSC_HI, 16'h0078);
    wr_reg(4'h3, 16'h0055);
    wr_reg(`CCS_ADDR_OSC_HI, 16'h009a);
    wr_reg(`CCS_ADDR_OSC_HI, 16'h0002);
    rd_reg(`CCS_ADDR_OSC_HI);
    chk(d, 16'h0000, "broken high key");
    set_new(SRC_POSC);
    wr_reg(`CCS_ADDR_OSC_LO, 16'h0001);
    rd_reg(`CCS_ADDR_OSC_LO);
    chk(d, 16'h0200, "unkeyed low write");
    $display("reset and key test done");
  endtask

  task automatic t_switch;
    @(posedge clk) fail_in <= 1;
    @(posedge clk) fail_in <= 0;
    rd_reg(`CCS_ADDR_OSC_LO);
    chk(d[3], 1, "fail flag set");
    request;
    // flags clear on the edge that leaves the compare step
    @(posedge clk);
    rd_reg(`CCS_ADDR_OSC_LO);
    chk({d[5], d[3], d[0]}, 3'b001, "lock fail cleared");
    ticks(10);
    rd_reg(`CCS_ADDR_OSC_LO);
    chk(d[0], 1, "crystal wait");
    chk(osc_enable[1], 1, "target enabled");
    osc_running <= 5'h1f;
    repeat (1100) @(posedge clk);
    ticks(9);
    rd_reg(`CCS_ADDR_OSC_LO);
    chk(d[0], 1, "nine ticks");
    ticks(1);
    wait_done;
    chk(d[14:12], SRC_POSC, "current copied");
    repeat (3) @(posedge clk);
    chk(sys_clk_sel, SRC_POSC, "system clock moved");
    chk(osc_enable[1:0], 2'b10, "old source off");
    wdog <= 1;
    repeat (2) @(posedge clk);
    chk(osc_enable[3], 1, "rc kept for watchdog");
    $display("crystal switch test done");
  endtask

  task automatic t_pll;
    xtal <= 0;
    set_new(SRC_POSCPLL); // primary to primary pll only
    request;
    ticks(10);
    repeat (40) @(posedge clk);
    rd_reg(`CCS_ADDR_OSC_LO);
    chk(d[0], 1, "held for lock");
    lock_in <= 1;
    repeat (3) @(posedge clk);
    ticks(10);
    wait_done;
    chk({d[14:12], d[5]}, {SRC_POSCPLL, 1'b1}, "pll switch");
    $display("pll switch test done");
  endtask

  task automatic t_ref;
    logic [17:0] tb [4];
    tb = '{{16'hb100, 2'b11}, {16'h9100, 2'b10},
           {16'ha100, 2'b10}, {16'hb100, 2'b00}};
    wr_reg(`CCS_ADDR_REF, 16'hffff);
    rd_reg(`CCS_ADDR_REF);
    chk(d, 16'hbf00, "ref readback");
    for (int n = 0; n < 5; n++)
      ref_period(16'h9000 | 16'(n << 8), (n == 0) ? 2 : 2 << n);
    ref_period(16'h8100, 300);
    sys_tick <= 1;
    ref_period(16'h8100, 2);
    sleep_mode <= 1;
    foreach (tb[i]) begin
      pmode <= tb[i][1];
      wr_reg(`CCS_ADDR_REF, tb[i][17:2]);
      repeat (3) @(posedge clk);
      chk(pin_oe, tb[i][0], "sleep output");
      chk(osc_enable[1], tb[i][0], "primary kept in sleep");
    end
    sleep_mode <= 0;
    wr_reg(`CCS_ADDR_REF, 16'h0000);
    repeat (3) @(posedge clk);
    chk({pin_oe, pin}, 2'b00, "ref disabled");
    $display("reference output test done");
  endtask

  // ==========================================================
  // main sequence and overall bound
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1;
    repeat (2) @(posedge clk);
    t_reset_keys;
    t_switch;
    t_pll;
    t_ref;
    test_done;
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    test_done;
  end
endmodule
